// ### verilog/rcrb_regs.vh
/*
 * Register map constants for the radio control register bank.
 * Assumes a byte-wide register access port with 6-bit addresses.
 */
// Functional notes
// - Wake status bit 0 reads 1 while a wake interrupt is pending.
// - A wakeup raises the interrupt request and sets wake pending together.
// - Reading the wake status register clears pending and the request.
// - Wake status is read-only; bits 7:1 are reserved.
// - Analog control bit 6 gates writes to registers 0x2E and 0x2F.
// - Identifier registers 0x3C-0x3F read their contents only with bit 5 set.
// - Analog control bit 2 enables driving the amplifier control pin.
// - Analog control bit 1 selects amplifier pin polarity: 1 active low.
// - Writing 1 to analog bit 0 resets all registers; bit self-clears.
// - Channel field 6:0 sets synthesizer frequency in 1 MHz steps.
// - Signal strength bit 5 reads 1 when the strength value is valid.
// - Signal strength bits 4:0 report strength, larger for stronger signals.
// - Transmit bias field 2:0 sets amplifier gain monotonically.
// - Wakeup occurs when power-down deasserts and the device becomes ready.
// - Wake enable bit 0 at 0x1C enables the wake interrupt.
// - One strength sample is captured on each entry to receive mode.
`ifndef RCRB_REGS_VH
`define RCRB_REGS_VH
`define RCRB_ADDR_CONTROL    6'h03
`define RCRB_ADDR_WAKE_EN    6'h1C
`define RCRB_ADDR_WAKE_STAT  6'h1D
`define RCRB_ADDR_ANALOG     6'h20
`define RCRB_ADDR_CHANNEL    6'h21
`define RCRB_ADDR_STRENGTH   6'h22
`define RCRB_ADDR_TX_POWER   6'h23
`define RCRB_ADDR_CAL_A      6'h2E
`define RCRB_ADDR_CAL_B      6'h2F
`define RCRB_ADDR_ID_FIRST   6'h3C
`define RCRB_ID_PAGE         4'hF
`define RCRB_CTRL_RX_BIT     7
`define RCRB_ANA_WR_GATE     6
`define RCRB_ANA_ID_READ     5
`define RCRB_ANA_AMP_ON      2
`define RCRB_ANA_AMP_POL     1
`define RCRB_ANA_SOFT_RESET  0
`define RCRB_ANA_WMASK       8'h66
`define RCRB_STR_VALID       5
`define RCRB_RST_CONTROL     8'h00
`define RCRB_RST_WAKE_EN     8'h00
`define RCRB_RST_ANALOG      8'h00
`define RCRB_RST_CHANNEL     8'h00
`define RCRB_RST_TX_POWER    8'h00
`define RCRB_RST_CAL         8'h00
// The identifier value is arbitrary and names no real part.
`define RCRB_ID_VALUE        32'h12345678
`endif

// ### verilog/rcrb_top.v
/*
 * Radio control register bank: wake status, analog control, channel,
 * signal strength and transmit power registers behind a byte access port.
 * Assumes the serial interface decoder delivers one-cycle read and write
 * strobes synchronous to CLK, and that the analog side supplies strength
 * samples and a ready indication.
 */
`include "rcrb_regs.vh"

module rcrb_top (
	// Clock, reset, enable
	input  wire       CLK,
	input  wire       RESET,
	input  wire       CE,
	// Register access port
	input  wire [5:0] ADDR,
	input  wire       WR_STB,
	input  wire [7:0] WDATA,
	input  wire       RD_STB,
	output reg  [7:0] RDATA,
	// Wake handling
	input  wire       POWER_DOWN_PIN,
	input  wire       SPI_READY,
	output reg        IRQ,
	// Signal strength source
	input  wire [4:0] STRENGTH_IN,
	input  wire       STRENGTH_VALID_IN,
	// Analog controls
	output reg        AMP_CONTROL_PIN,
	output reg        AMP_CONTROL_PIN_OE,
	output reg  [6:0] CHANNEL,
	output reg  [2:0] AMP_GAIN_SETTING,
	output reg        RX_MODE
);

	reg  [7:0] control_q;
	reg        wake_en_q;
	reg        wake_pend_q;
	reg  [7:0] analog_q;
	reg  [6:0] channel_q;
	reg  [2:0] gain_q;
	reg  [4:0] strength_q;
	reg        strength_ok_q;
	reg  [7:0] cal_a_q;
	reg  [7:0] cal_b_q;
	reg        awake_q;
	reg        rx_q;
	reg  [7:0] rdata_d;
	wire       wake_evt;
	wire       rd_wake;
	wire       wr_ana;
	wire       soft_rst;
	wire       rx_next;
	wire       rx_entry;
	wire [31:0] id_word;
	wire [1:0] id_sel;

	assign id_word  = `RCRB_ID_VALUE;
	assign id_sel   = ADDR[1:0];
	assign wr_ana   = WR_STB && (ADDR == `RCRB_ADDR_ANALOG);
	// The reset bit never stores; a write with it set restores all defaults.
	assign soft_rst = wr_ana && WDATA[`RCRB_ANA_SOFT_RESET];
	assign rd_wake  = RD_STB && (ADDR == `RCRB_ADDR_WAKE_STAT);
	// Wake fires on the rising edge of powered-up-and-ready.
	assign wake_evt = !POWER_DOWN_PIN && SPI_READY && !awake_q;
	assign rx_next  = (WR_STB && ADDR == `RCRB_ADDR_CONTROL) ?
	                  WDATA[`RCRB_CTRL_RX_BIT] : rx_q;
	assign rx_entry = rx_next && !rx_q;

	always @*
	begin
		rdata_d = 8'h00;
		case (ADDR)
			`RCRB_ADDR_CONTROL:   rdata_d = control_q;
			`RCRB_ADDR_WAKE_EN:   rdata_d = {7'h00, wake_en_q};
			`RCRB_ADDR_WAKE_STAT: rdata_d = {7'h00, wake_pend_q};
			`RCRB_ADDR_ANALOG:    rdata_d = analog_q;
			`RCRB_ADDR_CHANNEL:   rdata_d = {1'b0, channel_q};
			`RCRB_ADDR_STRENGTH:  rdata_d = {2'b00, strength_ok_q, strength_q};
			`RCRB_ADDR_TX_POWER:  rdata_d = {5'h00, gain_q};
			`RCRB_ADDR_CAL_A:     rdata_d = cal_a_q;
			`RCRB_ADDR_CAL_B:     rdata_d = cal_b_q;
			default:
			begin
				// Identifier bytes read as zero unless explicitly enabled.
				if (ADDR[5:2] == `RCRB_ID_PAGE &&
				    analog_q[`RCRB_ANA_ID_READ])
					rdata_d = id_word[{id_sel, 3'b000} +: 8];
			end
		endcase
	end

	always @(posedge CLK)
	begin
		if (RESET || (CE && soft_rst))
		begin
			control_q     <= `RCRB_RST_CONTROL;
			wake_en_q     <= 1'b0;
			wake_pend_q   <= 1'b0;
			analog_q      <= `RCRB_RST_ANALOG;
			channel_q     <= 7'h00;
			gain_q        <= 3'h0;
			strength_q    <= 5'h00;
			strength_ok_q <= 1'b0;
			cal_a_q       <= `RCRB_RST_CAL;
			cal_b_q       <= `RCRB_RST_CAL;
			awake_q       <= 1'b0;
			rx_q          <= 1'b0;
			RDATA         <= 8'h00;
			IRQ           <= 1'b0;
			AMP_CONTROL_PIN    <= 1'b0;
			AMP_CONTROL_PIN_OE <= 1'b0;
			CHANNEL          <= 7'h00;
			AMP_GAIN_SETTING <= 3'h0;
			RX_MODE          <= 1'b0;
		end
		else if (CE)
		begin
			awake_q <= !POWER_DOWN_PIN && SPI_READY;
			rx_q    <= rx_next;
			if (RD_STB)
				RDATA <= rdata_d;
			if (WR_STB)
			begin
				case (ADDR)
					`RCRB_ADDR_CONTROL:  control_q <= WDATA;
					`RCRB_ADDR_WAKE_EN:  wake_en_q <= WDATA[0];
					`RCRB_ADDR_ANALOG:   analog_q  <= WDATA & `RCRB_ANA_WMASK;
					`RCRB_ADDR_CHANNEL:  channel_q <= WDATA[6:0];
					`RCRB_ADDR_TX_POWER: gain_q    <= WDATA[2:0];
					`RCRB_ADDR_CAL_A:
					begin
						if (analog_q[`RCRB_ANA_WR_GATE])
							cal_a_q <= WDATA;
					end
					`RCRB_ADDR_CAL_B:
					begin
						if (analog_q[`RCRB_ANA_WR_GATE])
							cal_b_q <= WDATA;
					end
					default:
					begin
						// Wake status, strength and identifiers ignore writes.
					end
				endcase
			end
			// A new wake event wins over a same-cycle clearing read.
			if (wake_evt && wake_en_q)
				wake_pend_q <= 1'b1;
			else if (rd_wake)
				wake_pend_q <= 1'b0;
			IRQ <= (wake_evt && wake_en_q) || (wake_pend_q && !rd_wake);
			if (rx_entry)
			begin
				strength_q    <= STRENGTH_IN;
				strength_ok_q <= STRENGTH_VALID_IN;
			end
			AMP_CONTROL_PIN_OE <= analog_q[`RCRB_ANA_AMP_ON];
			AMP_CONTROL_PIN    <= analog_q[`RCRB_ANA_AMP_ON] &&
			                      (rx_q ^ analog_q[`RCRB_ANA_AMP_POL]);
			CHANNEL          <= channel_q;
			AMP_GAIN_SETTING <= gain_q;
			RX_MODE          <= rx_q;
		end
	end

endmodule

// ### test/rcrb_checker.sv
/* Port assertions for the register bank.
   Assumes binding onto rcrb_top. */
module rcrb_chk (
	input wire logic       CLK, RESET, CE, WR_STB, RD_STB,
	input wire logic [5:0] ADDR,
	input wire logic [7:0] WDATA, RDATA,
	input wire logic       POWER_DOWN_PIN, IRQ, AMP_CONTROL_PIN, AMP_CONTROL_PIN_OE,
	input wire logic [6:0] CHANNEL,
	input wire logic [2:0] AMP_GAIN_SETTING
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	wire logic wr_go = CE && WR_STB;
	wire logic rd_go = CE && RD_STB && !WR_STB;
	rd_wake_a: assert property (rd_go && ADDR == 6'h1D |=> RDATA == {7'h00, $past(IRQ)})
		else $error("wake read");
	irq_clr_a: assert property (rd_go && ADDR == 6'h1D && POWER_DOWN_PIN |=> !IRQ)
		else $error("irq clear");
	irq_hold_a: assert property (IRQ && !rd_go && !wr_go |=> IRQ)
		else $error("irq hold");
	pin_off_a: assert property (!AMP_CONTROL_PIN_OE |-> !AMP_CONTROL_PIN)
		else $error("amp pin");
	chan_wr_a: assert property (wr_go && ADDR == 6'h21 ##1 CE |=> CHANNEL == $past(WDATA[6:0], 2))
		else $error("channel");
	gain_wr_a: assert property (wr_go && ADDR == 6'h23 ##1 CE |=> AMP_GAIN_SETTING == $past(WDATA[2:0], 2))
		else $error("gain");
	soft_rst_a: assert property (wr_go && ADDR == 6'h20 && WDATA[0] |=> CHANNEL == 7'h00)
		else $error("soft reset");
	rst_gain_a: assert property (wr_go && ADDR == 6'h20 && WDATA[0] |=> AMP_GAIN_SETTING == 3'h0)
		else $error("soft reset gain");
	cover property (rd_go && ADDR == 6'h1D && IRQ);
	cover property (wr_go && ADDR == 6'h20 && WDATA[0]);
	cover property (AMP_CONTROL_PIN_OE && AMP_CONTROL_PIN);
endmodule
bind rcrb_top rcrb_chk chk_u (.*);

// ### test/rcrb_rf_src.sv
/* Strength sample source in place of the receive front end.
   Assumes a free-running CLK. */
module rcrb_rf_src (
	input  wire logic       CLK,
	output logic      [4:0] STRENGTH_IN,
	output logic            STRENGTH_VALID_IN
);
	timeunit 1ns;
	timeprecision 1ps;
	initial STRENGTH_IN = 5'h00;
	initial STRENGTH_VALID_IN = 1'b0;
	always @(posedge CLK)
	begin
		STRENGTH_IN <= STRENGTH_IN + 5'h07;
		STRENGTH_VALID_IN <= STRENGTH_IN[2];
	end
endmodule

// ### test/testbench.sv
/* Self-checking bench for the register bank.
   Assumes rcrb_top, its checker and the strength source. */
`include "rcrb_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       CLK = 0, RESET = 1, CE = 1, WR_STB = 0, RD_STB = 0, STRENGTH_VALID_IN;
	logic       POWER_DOWN_PIN = 1, SPI_READY = 0, IRQ, AMP_CONTROL_PIN, AMP_CONTROL_PIN_OE, RX_MODE;
	logic [5:0] ADDR = 6'h00;
	logic [7:0] WDATA = 8'h00, RDATA, es, rs;
	logic [4:0] STRENGTH_IN;
	logic [6:0] CHANNEL, ch;
	logic [2:0] AMP_GAIN_SETTING, g;
	int         error_cnt = 0, check_count = 0, cyc = 0, seed = 71016, i;
	rcrb_top    dut_u (.*);
	rcrb_rf_src rf_u (.*);
	always #5 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		check_count++;
		if (s !== e)
		begin
			$display("[FAIL] %s exp %h got %h", n, e, s);
			error_cnt++;
		end
	endtask
	task automatic wr(logic [5:0] a, logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR_STB <= 1'b1;
		@(posedge CLK);
		es = {2'b00, STRENGTH_VALID_IN, STRENGTH_IN};
		WR_STB <= 1'b0;
	endtask
	task automatic rd(logic [5:0] a, logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD_STB <= 1'b1;
		@(posedge CLK);
		RD_STB <= 1'b0;
		#1 chk("rdata", e, RDATA);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge CLK);
		RESET <= 1'b0;
		rd(6'h21, 8'h00);
		rd(6'h1D, 8'h00);
		wr(6'h1C, 8'h01);
		POWER_DOWN_PIN <= 1'b0;
		SPI_READY <= 1'b1;
		repeat (3) @(posedge CLK);
		#1 chk("irq", 8'h01, {7'h00, IRQ});
		wr(6'h1D, 8'h00);
		rd(6'h1D, 8'h01);
		chk("irq", 8'h00, {7'h00, IRQ});
		wr(6'h2E, 8'hA5);
		rd(6'h2E, 8'h00);
		wr(6'h20, 8'h40);
		wr(6'h2F, 8'hA5);
		rd(6'h2F, 8'hA5);
		rd(6'h3C, 8'h00);
		wr(6'h20, 8'h20);
		for (i = 0; i < 4; i++) rd(6'h3C + i[5:0], 8'(`RCRB_ID_VALUE >> (8 * i)));
		wr(6'h20, 8'h00);
		wr(6'h20, 8'h04);
		@(posedge CLK);
		#1 chk("amp", 8'h02, {6'h00, AMP_CONTROL_PIN_OE, AMP_CONTROL_PIN});
		wr(6'h20, 8'h06);
		@(posedge CLK);
		#1 chk("amp", 8'h03, {6'h00, AMP_CONTROL_PIN_OE, AMP_CONTROL_PIN});
		for (i = 0; i < 12; i++)
		begin
			ch = (i < 2) ? 7'(2 + 77 * i) : 7'(2 + {$random(seed)} % 78);
			g = (i == 0) ? 3'h7 : 3'($random(seed));
			wr(6'h21, {1'b0, ch});
			wr(6'h23, {5'h00, g});
			rd(6'h21, {1'b0, ch});
			chk("gain", {5'h00, g}, {5'h00, AMP_GAIN_SETTING});
		end
		CE <= 1'b0;
		wr(6'h21, 8'h55);
		CE <= 1'b1;
		rd(6'h21, {1'b0, ch});
		wr(6'h03, 8'h80);
		rs = es;
		rd(6'h22, rs);
		chk("rx", 8'h01, {7'h00, RX_MODE});
		wr(6'h22, 8'hFF);
		rd(6'h22, rs);
		wr(6'h20, 8'h01);
		rd(6'h21, 8'h00);
		rd(6'h20, 8'h00);
		chk("rx", 8'h00, {7'h00, RX_MODE});
		stop_test();
	end
endmodule
